// ---- inc/ccr_pkg.sv ----
package ccr_pkg;
    // register offsets
    localparam logic [7:0] CCR_ADDR_OP = 8'h00;
    localparam logic [7:0] CCR_ADDR_CHG = 8'h01;
    localparam logic [7:0] CCR_ADDR_PRE = 8'h02;
    localparam logic [7:0] CCR_ADDR_LIM = 8'h05;
    localparam logic [7:0] CCR_ADDR_STAT = 8'h06;
    localparam logic [7:0] CCR_ADDR_TEST1 = 8'h07;
    localparam logic [7:0] CCR_ADDR_TEST2 = 8'h10;
    // values after reset
    localparam logic [7:0] CCR_OP_RST = 8'hB9;
    localparam logic [7:0] CCR_CHG_RST = 8'hDC;
    localparam logic [7:0] CCR_PRE_RST = 8'h00;
    localparam logic [7:0] CCR_LIM_RST = 8'h00;
    localparam logic [7:0] CCR_STAT_RST = 8'h00;
    // bit positions
    localparam int CCR_OP_OVLO = 7;
    localparam int CCR_OP_BUCK = 6;
    localparam int CCR_OP_CAP = 2;
    localparam int CCR_OP_RES = 1;
    localparam int CCR_CHG_TRKL = 7;
    localparam int CCR_CHG_END = 6;
    localparam int CCR_CHG_WDT = 4;
    localparam int CCR_CHG_BMD = 3;
    localparam int CCR_CHG_FEED = 0;
    localparam int CCR_FLT_BAT = 1;
    localparam int CCR_FLT_WDT = 0;
    // field positions: threshold 7:4, precharge current 2:0, monitor 7:6, limit 4:0
    localparam int CCR_PRE_THR_LSB = 4;
    localparam int CCR_LIM_MON_LSB = 6;
    localparam logic [1:0] CCR_MON_FORBID = 2'h3;
    localparam logic [3:0] CCR_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] CCR_LAST_TX_BIT = 4'h7;

    typedef enum logic [2:0] {
        CCR_ST_IDLE = 3'b000,
        CCR_ST_ADDR = 3'b001,
        CCR_ST_ADDR_ACK = 3'b010,
        CCR_ST_RX = 3'b011,
        CCR_ST_RX_ACK = 3'b100,
        CCR_ST_TX = 3'b101,
        CCR_ST_TX_ACK = 3'b110
    } ccr_i2c_st_t;

    // configuration seen by the charger core
    typedef struct packed {
        logic overvoltage_lock_enable;
        logic buck_converter_enable;
        logic cap_load_on;
        logic res_load_on;
        logic trickle_phase_enable;
        logic charge_end_enable;
        logic charge_watchdog_enable;
        logic battery_missing_detect_enable;
        logic charge_feed_select;
        logic [3:0] fast_threshold_code;
        logic [2:0] precharge_current_code;
        logic [1:0] monitor_output_select;
        logic [4:0] input_current_limit_code;
        logic input_limit_active;
    } ccr_ctrl_t;

    // state reported by the charger core
    typedef struct packed {
        logic [3:0] phase;
        logic [3:0] fault_evt;
    } ccr_core_t;
endpackage

// ---- rtl/ccr_pin_sync.sv ----
`timescale 1ns/1ns
module ccr_pin_sync
    import ccr_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // pin and conditioned level
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } ccr_sync_t;

    ccr_sync_t q;
    ccr_sync_t d;

    always_comb begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    // idle bus is high, so reset to 1 avoids a false start
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    assign level = q.s2;
    assign rise = q.s2 & ~q.s3;
    assign fall = ~q.s2 & q.s3;
endmodule

// ---- rtl/ccr_sticky_flag.sv ----
`timescale 1ns/1ns
module ccr_sticky_flag
    import ccr_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // set and clear
    input wire logic set,
    input wire logic clr,
    output logic flag
);
    typedef struct packed {
        logic flag;
    } ccr_flag_t;

    ccr_flag_t q;
    ccr_flag_t d;

    // set wins so that an event in the clearing cycle is kept
    always_comb begin
        d = q;
        if (set) begin
            d.flag = 1'b1;
        end else if (clr) begin
            d.flag = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign flag = q.flag;
endmodule

// ---- rtl/ccr_regs.sv ----
`timescale 1ns/1ns
// How it works
// - Operation bit 7 enables overvoltage lockout; resets to one.
// - Operation bit 6 switches the step-down converter on; resets to zero.
// - Operation bit 2: zero follows capacitive switch pin, one forces transistor on.
// - Operation bit 1: zero follows resistive switch pin, one forces transistor on.
// - Charge function bit 7 enables the trickle phase; resets to one.
// - Charge function bit 6 enables ending charge after taper; resets to one.
// - Charge function bit 4 enables the charge watchdog; resets to one.
// - Charge function bit 3 enables battery connection error detection; resets to one.
// - Charge function bit 0 selects charge mode at zero, feed mode at one.
// - Precharge bits 7:4 set the fast-charge threshold, 2.1V to 3.6V.
// - Precharge bits 2:0 set precharge current, 50mA to 400mA.
// - Limit bits 7:6 select the monitor output; code 11 is never used.
// - Limit bits 4:0 set the input overcurrent limit, 100mA steps, resets zero.
// - Status is read-only, resets zero: four phase flags, four fault flags.
// - Fault flags clear when the converter enable bit is set.
// - Writes to the status register are ignored.
// - Input overcurrent limit acts only in the constant-current phase.
module ccr_regs
    import ccr_pkg::*;
#(
    // seven-bit bus address, value arbitrary
    parameter logic [6:0] SLAVE_ADDR = 7'h2A
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // two-wire bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // modulation switch pins
    input wire logic cap_switch_input,
    input wire logic res_switch_input,
    // charger core
    input wire ccr_core_t core,
    output ccr_ctrl_t ctrl
);
    typedef struct packed {
        ccr_i2c_st_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic ptr_phase;
        logic nack;
        logic [7:0] ptr;
        logic sda_oe;
        logic sda_o;
        logic [7:0] op;
        logic [7:0] chg;
        logic [7:0] pre;
        logic [7:0] lim;
        logic [1:0] mon;
        logic [3:0] phase;
        logic cap_on;
        logic res_on;
        logic limit_active;
        logic fault_clr;
    } ccr_main_t;

    ccr_main_t q;
    ccr_main_t d;

    logic scl_lvl;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic sda_rise;
    logic sda_fall;
    logic start_c;
    logic stop_c;
    logic wr_stb;
    logic [3:0] faults;
    logic [3:0] fault_set;
    logic [7:0] rd_byte;

    ccr_pin_sync u_scl (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin(scl_i),
        .level(scl_lvl),
        .rise(scl_rise),
        .fall(scl_fall)
    );

    ccr_pin_sync u_sda (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin(sda_i),
        .level(sda_lvl),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    // detection enables gate the events they govern
    always_comb begin
        fault_set = core.fault_evt;
        fault_set[CCR_FLT_BAT] = core.fault_evt[CCR_FLT_BAT] & q.chg[CCR_CHG_BMD];
        fault_set[CCR_FLT_WDT] = core.fault_evt[CCR_FLT_WDT] & q.chg[CCR_CHG_WDT];
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flt
            ccr_sticky_flag u_flag (
                .mclk(mclk),
                .rst_n(rst_n),
                .set(fault_set[gi]),
                .clr(q.fault_clr),
                .flag(faults[gi])
            );
        end
    endgenerate

    // read side of the map; unmapped and test addresses read zero
    always_comb begin
        case (q.ptr)
            CCR_ADDR_OP: rd_byte = q.op;
            CCR_ADDR_CHG: rd_byte = q.chg;
            CCR_ADDR_PRE: rd_byte = q.pre;
            CCR_ADDR_LIM: rd_byte = q.lim;
            CCR_ADDR_STAT: rd_byte = {q.phase, faults};
            default: rd_byte = 8'h00;
        endcase
    end

    assign start_c = sda_fall & scl_lvl;
    assign stop_c = sda_rise & scl_lvl;

    always_comb begin
        d = q;
        d.fault_clr = 1'b0;
        wr_stb = 1'b0;
        d.phase = core.phase;
        d.cap_on = q.op[CCR_OP_CAP] | cap_switch_input;
        d.res_on = q.op[CCR_OP_RES] | res_switch_input;
        // constant-current is the fast phase, and only while the converter runs
        d.limit_active = core.phase[1] & q.op[CCR_OP_BUCK];
        if (start_c) begin
            d.st = CCR_ST_ADDR;
            d.cnt = 4'h0;
            d.sda_oe = 1'b0;
        end else if (stop_c) begin
            d.st = CCR_ST_IDLE;
            d.sda_oe = 1'b0;
        end else begin
            case (q.st)
                CCR_ST_IDLE: begin
                    d.sda_oe = 1'b0;
                end
                CCR_ST_ADDR: begin
                    if (scl_rise) begin
                        d.sh = {q.sh[6:0], sda_lvl};
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == CCR_BITS_PER_BYTE) begin
                        d.cnt = 4'h0;
                        if (q.sh[7:1] == SLAVE_ADDR) begin
                            d.st = CCR_ST_ADDR_ACK;
                            d.rw = q.sh[0];
                            d.sda_oe = 1'b1;
                        end else begin
                            // not ours: wait for the next start
                            d.st = CCR_ST_IDLE;
                        end
                    end
                end
                CCR_ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (q.rw) begin
                            d.st = CCR_ST_TX;
                            d.sh = rd_byte;
                            d.ptr = q.ptr + 8'h01;
                            d.sda_oe = ~rd_byte[7];
                        end else begin
                            d.st = CCR_ST_RX;
                            d.ptr_phase = 1'b1;
                            d.sda_oe = 1'b0;
                        end
                    end
                end
                CCR_ST_RX: begin
                    if (scl_rise) begin
                        d.sh = {q.sh[6:0], sda_lvl};
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == CCR_BITS_PER_BYTE) begin
                        d.cnt = 4'h0;
                        d.st = CCR_ST_RX_ACK;
                        d.sda_oe = 1'b1;
                        d.ptr_phase = 1'b0;
                        if (q.ptr_phase) begin
                            d.ptr = q.sh;
                        end else begin
                            wr_stb = 1'b1;
                            d.ptr = q.ptr + 8'h01;
                        end
                    end
                end
                CCR_ST_RX_ACK: begin
                    if (scl_fall) begin
                        d.st = CCR_ST_RX;
                        d.sda_oe = 1'b0;
                    end
                end
                CCR_ST_TX: begin
                    if (scl_fall) begin
                        d.cnt = q.cnt + 4'h1;
                        if (q.cnt == CCR_LAST_TX_BIT) begin
                            d.st = CCR_ST_TX_ACK;
                            d.sda_oe = 1'b0;
                            d.cnt = 4'h0;
                        end else begin
                            d.sh = {q.sh[6:0], 1'b0};
                            d.sda_oe = ~q.sh[6];
                        end
                    end
                end
                CCR_ST_TX_ACK: begin
                    if (scl_rise) begin
                        d.nack = sda_lvl;
                    end else if (scl_fall) begin
                        if (q.nack) begin
                            d.st = CCR_ST_IDLE;
                        end else begin
                            d.st = CCR_ST_TX;
                            d.sh = rd_byte;
                            d.ptr = q.ptr + 8'h01;
                            d.sda_oe = ~rd_byte[7];
                        end
                    end
                end
                default: begin
                    d.st = CCR_ST_IDLE;
                    d.sda_oe = 1'b0;
                end
            endcase
        end
        // register writes; fixed bits are stored as sent so read-back shows them
        if (wr_stb) begin
            case (q.ptr)
                CCR_ADDR_OP: begin
                    d.op = q.sh;
                    d.fault_clr = ~q.op[CCR_OP_BUCK] & q.sh[CCR_OP_BUCK];
                end
                CCR_ADDR_CHG: d.chg = q.sh;
                CCR_ADDR_PRE: d.pre = q.sh;
                CCR_ADDR_LIM: begin
                    d.lim = q.sh;
                    // a forbidden monitor code leaves the pin on its last source
                    if (q.sh[7:6] != CCR_MON_FORBID) begin
                        d.mon = q.sh[7:6];
                    end
                end
                default: begin
                    // status and test addresses take no write
                    d.op = q.op;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= CCR_ST_IDLE;
            q.op <= CCR_OP_RST;
            q.chg <= CCR_CHG_RST;
            q.pre <= CCR_PRE_RST;
            q.lim <= CCR_LIM_RST;
            q.phase <= CCR_STAT_RST[7:4];
        end else begin
            q <= d;
        end
    end

    assign sda_o = q.sda_o;
    assign sda_oe = q.sda_oe;
    assign ctrl.overvoltage_lock_enable = q.op[CCR_OP_OVLO];
    assign ctrl.buck_converter_enable = q.op[CCR_OP_BUCK];
    assign ctrl.cap_load_on = q.cap_on;
    assign ctrl.res_load_on = q.res_on;
    assign ctrl.trickle_phase_enable = q.chg[CCR_CHG_TRKL];
    assign ctrl.charge_end_enable = q.chg[CCR_CHG_END];
    assign ctrl.charge_watchdog_enable = q.chg[CCR_CHG_WDT];
    assign ctrl.battery_missing_detect_enable = q.chg[CCR_CHG_BMD];
    assign ctrl.charge_feed_select = q.chg[CCR_CHG_FEED];
    assign ctrl.fast_threshold_code = q.pre[CCR_PRE_THR_LSB +: 4];
    assign ctrl.precharge_current_code = q.pre[2:0];
    assign ctrl.monitor_output_select = q.mon;
    assign ctrl.input_current_limit_code = q.lim[4:0];
    assign ctrl.input_limit_active = q.limit_active;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_ovlo_buck_write: assert property (wr_stb && q.ptr == CCR_ADDR_OP |=>
        ctrl.overvoltage_lock_enable == $past(q.sh[7]) && ctrl.buck_converter_enable == $past(q.sh[6]))
        else $error("operation enables not taken from write");
    a_cap_force_on: assert property (ctrl.cap_load_on == $past(q.op[CCR_OP_CAP] | cap_switch_input))
        else $error("capacitive load source wrong");
    a_res_pin_follow: assert property (!q.op[CCR_OP_RES] ##1 !q.op[CCR_OP_RES] |->
        ctrl.res_load_on == $past(res_switch_input))
        else $error("resistive load does not follow pin");
    a_chg_cfg_write: assert property (wr_stb && q.ptr == CCR_ADDR_CHG |=>
        {ctrl.trickle_phase_enable, ctrl.charge_end_enable, ctrl.charge_watchdog_enable,
         ctrl.battery_missing_detect_enable, ctrl.charge_feed_select}
        == {$past(q.sh[7]), $past(q.sh[6]), $past(q.sh[4]), $past(q.sh[3]), $past(q.sh[0])})
        else $error("charge function fields not taken");
    a_pre_fields_write: assert property (wr_stb && q.ptr == CCR_ADDR_PRE |=>
        ctrl.fast_threshold_code == $past(q.sh[7:4]) && ctrl.precharge_current_code == $past(q.sh[2:0]))
        else $error("precharge fields not taken");
    a_mon_never_forbid: assert property (ctrl.monitor_output_select != CCR_MON_FORBID)
        else $error("monitor select reached forbidden code");
    a_limit_code_write: assert property (wr_stb && q.ptr == CCR_ADDR_LIM |=>
        ctrl.input_current_limit_code == $past(q.sh[4:0]))
        else $error("input limit code not taken");
    a_fault_auto_clear: assert property (wr_stb && q.ptr == CCR_ADDR_OP && !q.op[6] && q.sh[6]
        ##1 fault_set == 4'h0 ##1 fault_set == 4'h0 |=> faults == 4'h0)
        else $error("faults not cleared on converter start");
    a_status_write_ignored: assert property (wr_stb && q.ptr == CCR_ADDR_STAT |=>
        $stable(q.op) && $stable(q.chg) && $stable(q.pre) && $stable(q.lim))
        else $error("status write changed a register");
    a_limit_cc_only: assert property (ctrl.input_limit_active |-> $past(core.phase[1]))
        else $error("limit active outside constant current");
    // phase follow, flag gating, sticky set, hold and monitor follow checks
    a_phase_follow_core: assert property (q.phase == $past(core.phase))
        else $error("status phase does not follow core");
    a_fault_set_wins: assert property (fault_set != 4'h0 |=>
        (faults & $past(fault_set)) == $past(fault_set))
        else $error("fault event not latched");
    a_bat_detect_gated: assert property (!q.chg[CCR_CHG_BMD] && !faults[CCR_FLT_BAT] |=>
        !faults[CCR_FLT_BAT])
        else $error("battery error flagged while detection off");
    a_wdt_detect_gated: assert property (!q.chg[CCR_CHG_WDT] && !faults[CCR_FLT_WDT] |=>
        !faults[CCR_FLT_WDT])
        else $error("watchdog expiry flagged while timer off");
    a_cfg_hold_idle: assert property (!wr_stb |=>
        $stable(q.op) && $stable(q.chg) && $stable(q.pre) && $stable(q.lim))
        else $error("configuration changed without a write");
    a_mon_follow_write: assert property (wr_stb && q.ptr == CCR_ADDR_LIM && q.sh[7:6] != CCR_MON_FORBID |=>
        ctrl.monitor_output_select == $past(q.sh[7:6]))
        else $error("monitor select not taken from write");
endmodule

// ---- tb/ccr_host_model.sv ----
`timescale 1ns/1ns
module ccr_host_model (
    // clock
    input wire logic mclk,
    // bus wires, sda_line is the resolved open-drain level
    input wire logic sda_line,
    output logic scl,
    output logic sda_m
);
    // 8 cycles a phase keeps both scl phases above the 4-cycle minimum
    localparam int PHASE = 8;

    initial begin
        scl = 1'h1;
        sda_m = 1'h1;
    end

    task automatic wait_ph();
        repeat (PHASE) @(negedge mclk);
    endtask

    // data moves two cycles after scl falls, never in the same sample as scl
    task automatic bit_cycle(input logic b, output logic seen);
        repeat (2) @(negedge mclk);
        sda_m = b;
        wait_ph();
        scl = 1'h1;
        wait_ph();
        seen = sda_line;
        scl = 1'h0;
    endtask

    task automatic start_cond();
        repeat (2) @(negedge mclk);
        sda_m = 1'h1;
        wait_ph();
        scl = 1'h1;
        wait_ph();
        sda_m = 1'h0;
        wait_ph();
        scl = 1'h0;
    endtask

    task automatic stop_cond();
        repeat (2) @(negedge mclk);
        sda_m = 1'h0;
        wait_ph();
        scl = 1'h1;
        wait_ph();
        sda_m = 1'h1;
        wait_ph();
    endtask

    // one byte and its acknowledge slot; sending FFh releases the line for reading
    task automatic xfer(input logic [7:0] tx, input logic ack_drv, output logic [7:0] rx, output logic ack_seen);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(tx[i], rx[i]);
        end
        bit_cycle(ack_drv, ack_seen);
    endtask

    task automatic write_bytes(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d[$],
                               output logic acked);
        logic [7:0] rx;
        logic s;
        start_cond();
        xfer({dev, 1'h0}, 1'h1, rx, s);
        acked = !s;
        xfer(ptr, 1'h1, rx, s);
        acked &= !s;
        foreach (d[i]) begin
            xfer(d[i], 1'h1, rx, s);
            acked &= !s;
        end
        stop_cond();
    endtask

    // single-byte read, ended by a master nack
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] val,
                            output logic acked);
        logic [7:0] rx;
        logic s;
        start_cond();
        xfer({dev, 1'h0}, 1'h1, rx, s);
        acked = !s;
        xfer(ptr, 1'h1, rx, s);
        start_cond();
        xfer({dev, 1'h1}, 1'h1, rx, s);
        xfer(8'hFF, 1'h1, val, s);
        stop_cond();
    endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ns
module tb;
    import ccr_pkg::*;
    localparam logic [6:0] DEV = 7'h2A;
    // test registers are never addressed
    localparam logic [7:0] MAPPED [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06};
    logic mclk = 1'h0;
    logic rst_n;
    logic scl;
    logic sda_m;
    logic sda_line;
    logic sda_o;
    logic sda_oe;
    logic cap_pin;
    logic res_pin;
    ccr_core_t core;
    ccr_ctrl_t ctrl;
    int miscompares;
    int n_compared;
    logic [7:0] op_m;
    logic [7:0] chg_m;
    logic [7:0] pre_m;
    logic [7:0] lim_m;
    logic [7:0] stat_m;

    // pull-up on the data wire: low while either side pulls
    assign sda_line = sda_m & !sda_oe;

    always #50 mclk = ~mclk;

    ccr_regs #(.SLAVE_ADDR(DEV)) i_ccr_regs (
        .mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .cap_switch_input(cap_pin), .res_switch_input(res_pin), .core(core), .ctrl(ctrl)
    );

    ccr_host_model i_ccr_host_model (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    function automatic ccr_ctrl_t exp_ctrl();
        return ccr_ctrl_t'({op_m[7], op_m[6], op_m[2] | cap_pin, op_m[1] | res_pin, chg_m[7], chg_m[6], chg_m[4],
                            chg_m[3], chg_m[0], pre_m[7:4], pre_m[2:0], lim_m[7:6], lim_m[4:0],
                            core.phase[1] & op_m[6]});
    endfunction

    function automatic logic [7:0] model_reg(input logic [7:0] a);
        case (a)
            8'h00: return op_m;
            8'h01: return chg_m;
            8'h02: return pre_m;
            8'h05: return lim_m;
            8'h06: return stat_m;
            default: return 8'h00;
        endcase
    endfunction

    task automatic settle_ctrl();
        repeat (4) @(negedge mclk);
        check("ctrl", 32'(ctrl), 32'(exp_ctrl()));
        check("sda_o", 32'(sda_o), 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        logic ak;
        i_ccr_host_model.read_reg(DEV, a, v, ak);
        check("read ack", 32'(ak), 32'h1);
        check("read data", 32'(v), 32'(exp));
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ak;
        i_ccr_host_model.write_bytes(DEV, a, '{d}, ak);
        check("write ack", 32'(ak), 32'h1);
        if (a == 8'h00 && !op_m[6] && d[6]) begin
            stat_m[3:0] = 4'h0;
        end
        case (a)
            8'h00: op_m = d;
            8'h01: chg_m = d;
            8'h02: pre_m = d;
            8'h05: lim_m = d;
            default: ;
        endcase
    endtask

    task automatic t_reset();
        settle_ctrl();
        foreach (MAPPED[i]) begin
            rd(MAPPED[i], model_reg(MAPPED[i]));
        end
    endtask

    task automatic t_writes();
        // fixed bits held as required, monitor code never 11, limit at most 18h
        logic [7:0] wa [9] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h02, 8'h02, 8'h05, 8'h05, 8'h05};
        logic [7:0] wd [9] = '{8'h7F, 8'hB9, 8'h05, 8'hDC, 8'hF7, 8'h50, 8'h58, 8'h8A, 8'h00};
        for (int i = 0; i < 9; i++) begin
            wr(wa[i], wd[i]);
            settle_ctrl();
            rd(wa[i], model_reg(wa[i]));
        end
    endtask

    task automatic t_pins();
        for (int f = 0; f < 2; f++) begin
            wr(8'h00, (f != 0) ? 8'hB7 : 8'hB9);
            for (int p = 0; p < 4; p++) begin
                cap_pin = p[1];
                res_pin = p[0];
                settle_ctrl();
            end
        end
        wr(8'h00, 8'hB9);
    endtask

    task automatic pulse_faults(input logic [3:0] f);
        core.fault_evt = f;
        @(negedge mclk);
        core.fault_evt = 4'h0;
    endtask

    task automatic t_status();
        logic ak;
        core.phase = 4'hA;
        pulse_faults(4'hF);
        stat_m = 8'hAF;
        rd(8'h06, stat_m);
        core.phase = 4'h2;
        stat_m[7:4] = 4'h2;
        settle_ctrl();
        wr(8'h00, 8'hF9);
        settle_ctrl();
        rd(8'h06, stat_m);
        // second byte of the burst lands on the status register and must vanish
        i_ccr_host_model.write_bytes(DEV, 8'h05, '{8'h18, 8'hFF}, ak);
        check("burst ack", 32'(ak), 32'h1);
        lim_m = 8'h18;
        rd(8'h05, lim_m);
        rd(8'h06, stat_m);
        // with battery and watchdog detection off only the other two faults stick
        wr(8'h01, 8'hC4);
        pulse_faults(4'hF);
        stat_m[3:0] = 4'hC;
        rd(8'h06, stat_m);
        settle_ctrl();
    endtask

    task automatic t_refused();
        logic [7:0] v;
        logic ak;
        i_ccr_host_model.read_reg(7'h15, 8'h00, v, ak);
        check("foreign address ack", 32'(ak), 32'h0);
    endtask

    task automatic end_of_test();
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'h0;
        cap_pin = 1'h0;
        res_pin = 1'h0;
        core = '0;
        miscompares = 0;
        n_compared = 0;
        op_m = 8'hB9;
        chg_m = 8'hDC;
        pre_m = 8'h00;
        lim_m = 8'h00;
        stat_m = 8'h00;
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'h1;
        repeat (5) @(negedge mclk);
        t_reset();
        t_writes();
        t_pins();
        t_status();
        t_refused();
        end_of_test();
    end

    // the sequence takes about 24k cycles, so this limit only trips on a hang
    initial begin
        repeat (80000) @(posedge mclk);
        miscompares++;
        end_of_test();
    end
endmodule
